/* File: bench/nfcf_peer_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// far-side sink for the modulator bytes, prompt or stalling
module nfcf_peer_model
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       slow_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out
);
  logic [1:0] cnt_q;
  logic [7:0] got [$];
  // slow mode takes one cycle in four, so the two-entry buffer fills up
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      cnt_q        <= 2'h0;
      tx_ready_out <= 1'b0;
    end
    else
    begin
      cnt_q        <= cnt_q + 2'h1;
      tx_ready_out <= !slow_in || (cnt_q == 2'h3);
    end
  end
  // every accepted byte is kept in arrival order
  always_ff @(posedge clk_in)
  begin
    if (resetn_in && tx_valid_in && tx_ready_out)
      got.push_back(tx_data_in);
  end
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`include "nfcf_consts.svh"
module testbench;
  logic        clk_in      = 1'b0;
  logic        resetn_in   = 1'b0;
  logic        spi_sclk_in = 1'b0;
  logic        spi_csn_in  = 1'b1;
  logic        spi_mosi_in = 1'b0;
  logic        slow_in     = 1'b0;
  logic        spi_miso_out, tx_valid_out, tx_ready_in;
  logic        field_on_out, load_mod_out, rate_424_out;
  logic [7:0]  tx_data_out, v;
  logic [7:0]  rx_b [$];
  logic [7:0]  pl [$];
  logic [10:0] rows [5] = '{{8'h32, 3'b100}, {8'h33, 3'b101}, {8'h22, 3'b010},
                            {8'h23, 3'b011}, {8'h21, 3'b010}};
  int          mismatches  = 0;
  int          checks_done = 0;

  always #10 clk_in = ~clk_in;

  nfcf_p2p_tx_sequencer i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .spi_sclk_in(spi_sclk_in), .spi_csn_in(spi_csn_in), .spi_mosi_in(spi_mosi_in),
    .spi_miso_out(spi_miso_out), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
    .tx_ready_in(tx_ready_in), .field_on_out(field_on_out), .load_mod_out(load_mod_out),
    .rate_424_out(rate_424_out));
  nfcf_peer_model i_peer (.clk_in(clk_in), .resetn_in(resetn_in), .slow_in(slow_in),
    .tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in));

  // ========================================================================
  // comparison and verdict
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task summarize();
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ========================================================================
  // serial port, mode 0: two clocks low then two high per bit, msb first
  task xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clk_in);
      spi_sclk_in <= 1'b0;
      spi_mosi_in <= b[i];
      repeat (2) @(posedge clk_in);
      r[i] = spi_miso_out;
      spi_sclk_in <= 1'b1;
      @(posedge clk_in);
    end
  endtask
  // whole transaction, chip select released before the next step
  task txn(input logic [7:0] b [$]);
    logic [7:0] r;
    rx_b = {};
    @(posedge clk_in);
    spi_csn_in <= 1'b0;
    foreach (b[k])
    begin
      xfer(b[k], r);
      rx_b.push_back(r);
    end
    @(posedge clk_in);
    spi_sclk_in <= 1'b0;
    spi_csn_in  <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask
  task rd(input logic [5:0] a);
    txn('{{2'b01, a}, 8'h00});
    v = rx_b[1];
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] d [$]);
    logic [15:0] c;
    c = `NFCF_CRC_INIT;
    foreach (d[k])
      for (int i = 7; i >= 0; i--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k][i]) ? `NFCF_CRC_POLY : 16'h0000);
    return c;
  endfunction
  // ========================================================================
  // one full send: fifo reset, transmit command, length, payload
  task automatic send(input logic slow);
    logic [7:0]  e [$];
    logic [15:0] c;
    int          base;
    int          t;
    base = i_peer.got.size();
    slow_in <= slow;
    txn('{{1'b1, `NFCF_CMD_FIFO_RESET}});
    txn('{{1'b1, `NFCF_CMD_TX_CRC}});
    txn('{{2'b00, `NFCF_REG_LEN1}, 8'(pl.size() >> 4), 8'(pl.size() << 4)});
    e = pl;
    e.push_front({2'b00, `NFCF_REG_FIFO});
    txn(e);
    c = crc16(pl);
    e = pl;
    e.push_back(c[15:8]);
    e.push_back(c[7:0]);
    for (t = 0; t < 3000 && i_peer.got.size() < base + e.size(); t++)
      @(posedge clk_in);
    if (t == 3000)
    begin
      mismatches++;
      summarize();
    end
    else
      foreach (e[k])
        check(i_peer.got[base+k], e[k]);
  endtask
  // ========================================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_in);
    check({field_on_out, load_mod_out, tx_valid_out}, 3'b000);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    check({field_on_out, load_mod_out, rate_424_out}, 3'b010);
    rd(`NFCF_REG_PROT);
    check(v, `NFCF_PROT_RESET);
    rd(`NFCF_REG_LEN2);
    check(v, `NFCF_LEN_RESET);
    txn('{8'h05, 8'h77});
    rd(6'h05);
    check(v, 8'h00);
    // protocol select table: readback and field, load and rate outputs
    foreach (rows[k])
    begin
      txn('{{2'b00, `NFCF_REG_PROT}, rows[k][10:3]});
      rd(`NFCF_REG_PROT);
      check(v, rows[k][10:3]);
      check({field_on_out, load_mod_out, rate_424_out}, rows[k][2:0]);
    end
    // seventeen bytes into an idle fifo: one dropped, overflow flagged
    pl = {};
    repeat (17) pl.push_back(8'h5a);
    pl.push_front({2'b00, `NFCF_REG_FIFO});
    txn(pl);
    rd(`NFCF_REG_STAT);
    check(v, 8'h50);
    txn('{{1'b1, `NFCF_CMD_FIFO_RESET}});
    rd(`NFCF_REG_STAT);
    check(v, 8'h00);
    // transmit with no length stays busy until a fifo reset, or a length write plus that many payload bytes and the crc; here a fifo reset ends it
    txn('{{1'b1, `NFCF_CMD_TX_CRC}});
    rd(`NFCF_REG_STAT);
    check(v, 8'h80);
    txn('{{1'b1, `NFCF_CMD_FIFO_RESET}});
    rd(`NFCF_REG_STAT);
    check(v, 8'h00);
    // active target answer: guard time, own field off, protocol select, settle
    repeat (`NFCF_GUARD_CYCLES) @(posedge clk_in);
    check({field_on_out, load_mod_out}, 2'b01);
    txn('{{2'b00, `NFCF_REG_PROT}, 8'h32});
    repeat (`NFCF_SETTLE_CYCLES) @(posedge clk_in);
    check(field_on_out, 1'b1);
    // stale bytes must be flushed by the send's own fifo reset
    txn('{{2'b00, `NFCF_REG_FIFO}, 8'hee, 8'hee});
    pl = '{8'h01, 8'h23, 8'h45};
    send(1'b1);
    // after the active send: field off, filter band and fifo level set
    txn('{{2'b00, `NFCF_REG_PROT}, 8'h21});
    txn('{{2'b00, `NFCF_REG_RXFILT}, 8'h80});
    txn('{{2'b00, `NFCF_REG_FIFOLVL}, 8'h0f});
    check({field_on_out, load_mod_out}, 2'b01);
    // passive initiator setup once the collision check found no field
    txn('{{2'b00, `NFCF_REG_PROT}, 8'h32});
    // fifo-depth payload of sixteen bytes with a stalling sink, then a single byte back to back
    pl = {};
    for (int k = 0; k < 16; k++)
      pl.push_back(8'(k * 17 + 3));
    send(1'b1);
    // passive target answers at 212 kbps when anticollision starts
    txn('{{2'b00, `NFCF_REG_PROT}, 8'h22});
    pl = '{8'hc3};
    send(1'b0);
    summarize();
  end
endmodule

/* File: logic/nfcf_consts.svh */
`ifndef NFCF_CONSTS_SVH
`define NFCF_CONSTS_SVH
// ==========================================================================
// register map, six-bit addresses on the serial port
`define NFCF_REG_PROT        6'h01
`define NFCF_REG_STAT        6'h1c
`define NFCF_REG_LEN1        6'h1d
`define NFCF_REG_LEN2        6'h1e
`define NFCF_REG_FIFO        6'h1f
// host-side receiver filter and fifo level registers, not held in this block
`define NFCF_REG_RXFILT      6'h0a
`define NFCF_REG_FIFOLVL     6'h14
// ==========================================================================
// reset values
`define NFCF_PROT_RESET      8'h21
`define NFCF_LEN_RESET       8'h00
// ==========================================================================
// direct command codes, sent with bit 7 of the first byte set
`define NFCF_CMD_FIFO_RESET  7'h0f
`define NFCF_CMD_TX_CRC      7'h11
// ==========================================================================
// command byte fields
`define NFCF_B_CMD           7
`define NFCF_B_READ          6
// ==========================================================================
// protocol select fields
`define NFCF_P_OWN_FIELD     4
`define NFCF_P_RATE_LO       0
`define NFCF_P_RATE_HI       3
`define NFCF_RATE_212        4'h2
`define NFCF_RATE_424        4'h3
// ==========================================================================
// fifo and crc
`define NFCF_FIFO_DEPTH      16
`define NFCF_FIFO_AW         4
`define NFCF_CRC_POLY        16'h1021
`define NFCF_CRC_INIT        16'h0000
// ==========================================================================
// host timing in clock cycles at 20 ns: guard time and protocol settle time
`define NFCF_GUARD_CYCLES    2800
`define NFCF_SETTLE_CYCLES   50000
`endif

/* File: logic/nfcf_p2p_tx_sequencer.sv */
`timescale 1ns/1ps
`include "nfcf_consts.svh"
module nfcf_p2p_tx_sequencer
  import nfcf_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       spi_sclk_in,
  input  wire logic       spi_csn_in,
  input  wire logic       spi_mosi_in,
  output logic            spi_miso_out,
  output logic [7:0]      tx_data_out,
  output logic            tx_valid_out,
  input  wire logic       tx_ready_in,
  output logic            field_on_out,
  output logic            load_mod_out,
  output logic            rate_424_out
);
  // ========================================================================
  // serial register port
  logic [7:0]                  prot_q;
  logic [7:0]                  len1_q;
  logic [7:0]                  len2_q;
  logic                        sclk_q;
  logic [6:0]                  sh_q;
  logic [2:0]                  bit_q;
  logic                        first_q;
  logic                        rd_q;
  logic [5:0]                  addr_q;
  logic [7:0]                  rsh_q;
  logic                        rise;
  logic                        fall;
  logic                        byte_done;
  logic [7:0]                  rx_byte;
  logic                        cmd_reset;
  logic                        cmd_tx;
  logic                        wr_en;
  logic [7:0]                  rd_val;
  logic [5:0]                  rd_addr;

  assign rise      = spi_sclk_in & ~sclk_q & ~spi_csn_in;
  assign fall      = ~spi_sclk_in & sclk_q & ~spi_csn_in;
  assign rx_byte   = {sh_q, spi_mosi_in};
  assign byte_done = rise && (bit_q == 3'h7);
  assign cmd_reset = byte_done && first_q && rx_byte[`NFCF_B_CMD]
                     && (rx_byte[6:0] == `NFCF_CMD_FIFO_RESET);
  assign cmd_tx    = byte_done && first_q && rx_byte[`NFCF_B_CMD]
                     && (rx_byte[6:0] == `NFCF_CMD_TX_CRC);
  assign wr_en     = byte_done && !first_q && !rd_q;
  assign rd_addr   = first_q ? rx_byte[5:0] : addr_q;

  // bit framing; chip select high restarts a transaction
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || spi_csn_in)
    begin
      sclk_q  <= 1'b0;
      sh_q    <= 7'h00;
      bit_q   <= 3'h0;
      first_q <= 1'b1;
      rd_q    <= 1'b0;
      addr_q  <= 6'h00;
    end
    else
    begin
      sclk_q <= spi_sclk_in;
      if (rise)
      begin
        sh_q  <= rx_byte[6:0];
        bit_q <= bit_q + 3'h1;
      end
      if (byte_done)
      begin
        first_q <= 1'b0;
        if (first_q)
        begin
          rd_q   <= rx_byte[`NFCF_B_READ];
          addr_q <= rx_byte[5:0];
        end
        else if (addr_q != `NFCF_REG_FIFO)
          addr_q <= addr_q + 6'h01; // burst walks up, fifo address stays put
      end
    end
  end

  // writable registers
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      prot_q <= `NFCF_PROT_RESET;
      len1_q <= `NFCF_LEN_RESET;
      len2_q <= `NFCF_LEN_RESET;
    end
    else if (wr_en)
    begin
      case (addr_q)
        `NFCF_REG_PROT: prot_q <= rx_byte;
        `NFCF_REG_LEN1: len1_q <= rx_byte;
        `NFCF_REG_LEN2: len2_q <= rx_byte;
        default: ;
      endcase
    end
  end

  // ========================================================================
  // payload fifo and transmit engine
  logic [7:0]                  mem_q [`NFCF_FIFO_DEPTH];
  logic [`NFCF_FIFO_AW-1:0]    wp_q;
  logic [`NFCF_FIFO_AW-1:0]    rp_q;
  logic [`NFCF_FIFO_AW:0]      cnt_q;
  logic                        ovf_q;
  nfcf_state_t                 st_q;
  logic [11:0]                 left_q;
  logic [15:0]                 crc_q;
  logic                        crc_lo_q;
  logic                        push;
  logic                        pop;
  logic                        b_push;
  logic [7:0]                  b_in;
  logic                        b_room;

  assign push = wr_en && (addr_q == `NFCF_REG_FIFO) && (cnt_q != 5'h10);
  assign pop  = (st_q == NFCF_ST_DATA) && (left_q != 12'h000)
                && (cnt_q != 5'h00) && b_room;

  // status read: busy, overflow, fill level
  always_comb
  begin
    case (rd_addr)
      `NFCF_REG_PROT: rd_val = prot_q;
      `NFCF_REG_LEN1: rd_val = len1_q;
      `NFCF_REG_LEN2: rd_val = len2_q;
      `NFCF_REG_STAT: rd_val = {(st_q != NFCF_ST_IDLE), ovf_q, 1'b0, cnt_q};
      default:        rd_val = 8'h00;
    endcase
  end

  // read data shifts out on falling edges, msb first
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      rsh_q        <= 8'h00;
      spi_miso_out <= 1'b0;
    end
    else if (byte_done && (first_q ? rx_byte[`NFCF_B_READ] : rd_q))
      rsh_q <= rd_val;
    else if (fall)
    begin
      spi_miso_out <= rsh_q[7];
      rsh_q        <= {rsh_q[6:0], 1'b0};
    end
  end

  // crc-16 over one byte, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
      r = r[15] ? ({r[14:0], 1'b0} ^ `NFCF_CRC_POLY) : {r[14:0], 1'b0};
    return r;
  endfunction

  // fifo storage; a reset command drops everything held
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || cmd_reset)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wp_q] <= rx_byte;
        wp_q        <= wp_q + 4'h1;
      end
      if (pop)
        rp_q <= rp_q + 4'h1;
      cnt_q <= cnt_q + {4'h0, push} - {4'h0, pop};
      if (wr_en && (addr_q == `NFCF_REG_FIFO) && !push)
        ovf_q <= 1'b1; // a full fifo drops the byte, flag stays until reset
    end
  end

  // frame sender: payload count from the length pair, then two crc bytes
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || cmd_reset)
    begin
      st_q     <= NFCF_ST_IDLE;
      left_q   <= 12'h000;
      crc_q    <= `NFCF_CRC_INIT;
      crc_lo_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        NFCF_ST_IDLE:
        begin
          if (cmd_tx)
          begin
            st_q   <= NFCF_ST_DATA;
            crc_q  <= `NFCF_CRC_INIT;
            left_q <= {len1_q, len2_q[7:4]};
          end
        end
        NFCF_ST_DATA:
        begin
          // length may still be written after the command, so follow it
          // every popped byte enters the crc, even when the length is rewritten
          if (pop)
            crc_q <= crc_step(crc_q, mem_q[rp_q]);
          if (wr_en && (addr_q == `NFCF_REG_LEN1 || addr_q == `NFCF_REG_LEN2))
            left_q <= (addr_q == `NFCF_REG_LEN1) ? {rx_byte, len2_q[7:4]}
                                                 : {len1_q, rx_byte[7:4]};
          else if (pop)
            left_q <= left_q - 12'h001;
          else if ((left_q == 12'h000) && ({len1_q, len2_q[7:4]} != 12'h000))
          begin
            st_q     <= NFCF_ST_CRC;
            crc_lo_q <= 1'b0;
          end
        end
        NFCF_ST_CRC:
        begin
          if (b_room)
          begin
            crc_lo_q <= 1'b1;
            if (crc_lo_q)
              st_q <= NFCF_ST_IDLE;
          end
        end
        default: st_q <= NFCF_ST_IDLE;
      endcase
    end
  end

  assign b_push = pop || ((st_q == NFCF_ST_CRC) && b_room);
  assign b_in   = pop ? mem_q[rp_q] : (crc_lo_q ? crc_q[7:0] : crc_q[15:8]);

  // ========================================================================
  // two-entry buffer toward the modulator; a stalled receiver loses nothing
  logic [7:0]                  b1_q;
  logic                        b1v_q;
  logic                        take;

  assign take   = tx_valid_out && tx_ready_in;
  assign b_room = !b1v_q;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || cmd_reset)
    begin
      tx_valid_out <= 1'b0;
      tx_data_out  <= 8'h00;
      b1v_q        <= 1'b0;
      b1_q         <= 8'h00;
    end
    else
    begin
      if (!tx_valid_out || take)
      begin
        tx_valid_out <= b1v_q || b_push;
        tx_data_out  <= b1v_q ? b1_q : b_in;
        b1v_q        <= b1v_q && b_push;
        b1_q         <= b_in;
      end
      else if (b_push)
      begin
        b1v_q <= 1'b1;
        b1_q  <= b_in;
      end
    end
  end

  // ========================================================================
  // rf front-end steering from protocol select
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      field_on_out <= 1'b0;
      load_mod_out <= 1'b0;
      rate_424_out <= 1'b0;
    end
    else
    begin
      field_on_out <= prot_q[`NFCF_P_OWN_FIELD];
      load_mod_out <= !prot_q[`NFCF_P_OWN_FIELD];
      rate_424_out <= (prot_q[`NFCF_P_RATE_HI:`NFCF_P_RATE_LO] == `NFCF_RATE_424);
    end
  end

  // ========================================================================
  // checks
  chk_fifo_reset_empty: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cmd_reset |=> (cnt_q == 5'h00) && (st_q == NFCF_ST_IDLE) && !tx_valid_out)
    else $error("fifo not empty after reset command");
  chk_tx_cmd_start: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (cmd_tx && st_q == NFCF_ST_IDLE) |=> (st_q == NFCF_ST_DATA))
    else $error("transmit command did not start the frame");
  chk_crc_two_bytes: assert property (@(posedge clk_in) disable iff (!resetn_in || cmd_reset)
    (st_q == NFCF_ST_CRC && b_room && crc_lo_q) |=> (st_q == NFCF_ST_IDLE))
    else $error("crc phase did not end after low byte");
  chk_load_mod_mode: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $past(resetn_in) |-> (load_mod_out == !$past(prot_q[`NFCF_P_OWN_FIELD]))
                         && (field_on_out != load_mod_out))
    else $error("target not load modulating");
  chk_field_select: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_en && addr_q == `NFCF_REG_PROT) |=> ##1 (field_on_out == $past(rx_byte[4], 2)))
    else $error("field modulation does not follow protocol select");
  chk_rate_select: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_en && addr_q == `NFCF_REG_PROT && rx_byte[3:0] == `NFCF_RATE_212) |=> ##1 !rate_424_out)
    else $error("212 kbps setting gave 424 kbps");
  chk_buffer_hold: assert property (@(posedge clk_in) disable iff (!resetn_in || cmd_reset)
    (tx_valid_out && !tx_ready_in) |=> (tx_valid_out && $stable(tx_data_out)))
    else $error("stalled output word changed");
  chk_pop_in_data: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (pop && !cmd_reset && !(wr_en && (addr_q == `NFCF_REG_LEN1
                                      || addr_q == `NFCF_REG_LEN2)))
      |=> (left_q == $past(left_q) - 12'h001))
    else $error("payload count did not follow a fifo pop");
  cov_frame_done: cover property (@(posedge clk_in) disable iff (!resetn_in)
    (st_q == NFCF_ST_CRC) ##1 (st_q == NFCF_ST_IDLE));
  cov_stall: cover property (@(posedge clk_in) disable iff (!resetn_in)
    tx_valid_out && !tx_ready_in && b1v_q);
  cov_reset_mid_frame: cover property (@(posedge clk_in) disable iff (!resetn_in)
    cmd_reset && (st_q == NFCF_ST_DATA));
endmodule

/* File: logic/nfcf_pkg.sv */
package nfcf_pkg;
  // ========================================================================
  // transmit engine states, one-hot
  typedef enum logic [2:0]
  {
    NFCF_ST_IDLE = 3'b001,
    NFCF_ST_DATA = 3'b010,
    NFCF_ST_CRC  = 3'b100
  } nfcf_state_t;
endpackage
